/* verilog/capture_compare_timer16_pkg.sv */
// package for the 16-bit capture/compare timer
// assumes a classic Wishbone register bus with 8-bit registers in the low data lane
package capture_compare_timer16_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_EVENT_FLAGS   = 8'hC8;
  localparam logic [7:0] IDX_CLEAR_TOGGLE  = 8'hEF;
  localparam logic [7:0] IDX_CONTROL       = 8'hC0;
  localparam logic [7:0] IDX_EDGE_CONTROL  = 8'hC1;
  localparam logic [7:0] IDX_SET_ENABLE    = 8'hEE;
  localparam logic [7:0] IDX_COUNT_LO      = 8'hD0;
  localparam logic [7:0] IDX_COUNT_HI      = 8'hD1;
  localparam logic [7:0] IDX_CAPTURE_BASE  = 8'hD2;  // a lo, a hi, b lo ... d hi
  localparam logic [7:0] IDX_COMPARE_BASE  = 8'hDA;  // set lo/hi, clear lo/hi, toggle lo/hi
  localparam logic [7:0] IDX_PORT          = 8'hE0;

  // ----------------------------------------------------------------
  // timer_control fields
  // ----------------------------------------------------------------
  localparam int CTL_WORD_IRQ_SEL  = 7;
  localparam int CTL_BYTE_IRQ_SEL  = 6;
  localparam int CTL_EXT_CLEAR_EN  = 5;
  localparam int CTL_BYTE_OVF_FLAG = 4;
  localparam int CTL_PRESCALE_LSB  = 2;
  localparam int CTL_MODE_LSB      = 0;

  // clock modes
  localparam logic [1:0] MODE_HALTED   = 2'h0;
  localparam logic [1:0] MODE_SYSCLK   = 2'h1;
  localparam logic [1:0] MODE_TEST     = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  // timer_event_flags fields
  localparam int FLG_WORD_OVF    = 7;
  localparam int FLG_COMPARE_LSB = 4;
  localparam int FLG_CAPTURE_LSB = 0;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [7:0]  RST_PORT    = 8'h00;
  localparam int          SYS_DIVIDE  = 12;  // system clocks per internal count tick

  // pin vector positions after synchronisation
  localparam int PIN_COUNT = 4;
  localparam int PIN_CLEAR = 5;

  // ----------------------------------------------------------------
  // whole state of the timer block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]        syncA;
    logic [5:0]        syncB;
    logic [5:0]        syncC;
    logic [5:0]        level;
    logic [3:0]        divider;
    logic [2:0]        prescale;
    logic [15:0]       count;
    logic [7:0]        control;
    logic [7:0]        edgeCtl;
    logic [7:0]        setEnable;
    logic [7:0]        clearToggle;
    logic [7:0]        flags;
    logic [7:0]        port;
    logic [3:0][15:0]  capture;
    logic [2:0][15:0]  compare;
    logic [2:0]        matchPrev;
    logic              ack;
    logic [31:0]       readData;
  } state_t;

endpackage : capture_compare_timer16_pkg

/* verilog/capture_compare_timer16.sv */
// 16-bit timer with prescaler, four capture registers, three compare registers
// and an 8-bit compare-driven output port, reached over classic Wishbone.
// assumes pins are asynchronous to clk; lowPower comes from logic on clk.
//
// Summary of operation
// (RULE1) prescaler divides by 1, 2, 4 or 8
// (RULE2) mode picks halt, clk/12 or count pin
// (RULE3) prescaler clears on config change or reset
// (RULE4) counter bytes read live, no snapshot latch
// (RULE5) counter not writable; external clear when enabled
// (RULE6) idle/power-down holds counter and prescaler cleared
// (RULE7) capture edge copies counter, sets capture flag
// (RULE8) per-input rising/falling edge enable bits
// (RULE9) compare equality sets compare flag
// (RULE10) set-compare match sets enabled port bits 0-5
// (RULE11) clear-compare match clears enabled port bits 0-5
// (RULE12) toggle-compare match toggles enabled bits 6,7
// (RULE13) direction bit picks level after toggle
// (RULE14) clear beats set on simultaneous match
// (RULE15) chip reset clears compare registers
// (RULE16) flag register layout: overflow, compares, captures
// (RULE17) software port access keeps compare actions
// (RULE18) byte and word overflow set their flags
// (RULE19) flags cleared only by software
// (RULE20) count pin edge rate at most clk/12
// (RULE21) pins synchronised, edges from sample compare
// (RULE22) match acts once when equality begins
`timescale 1ns/1ns

module capture_compare_timer16 #(
  parameter int SysDivide = capture_compare_timer16_pkg::SYS_DIVIDE
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        externalCountPin,
  input  wire logic        externalClearPin,
  input  wire logic        captureInputA,
  input  wire logic        captureInputB,
  input  wire logic        captureInputC,
  input  wire logic        captureInputD,
  input  wire logic        lowPower,
  output logic      [7:0]  portOut
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (SysDivide < 2 || SysDivide > 16) begin : g_bad_divide
    $error("SysDivide must lie in 2..16 for the 4-bit divider");
  end

  localparam logic [3:0] DIV_LAST = 4'(SysDivide - 1);

  capture_compare_timer16_pkg::state_t s_reg;
  capture_compare_timer16_pkg::state_t s_next;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic [5:0]  pinsRaw;
  logic [5:0]  stable;
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic        busReq;
  logic        wrCommit;
  logic [7:0]  index;
  logic [7:0]  wrByte;
  logic        ctrlWrite;
  logic        flagWrite;
  logic        portWrite;
  logic        cfgChange;
  logic        extClear;
  logic        timerHold;
  logic        preClear;
  logic [1:0]  mode;
  logic [1:0]  prescaleSel;
  logic        divTick;
  logic        tick;
  logic [2:0]  preMask;
  logic        cntStep;
  logic        byteOvf;
  logic        wordOvf;
  logic [3:0]  capEv;
  logic [2:0]  matchNow;
  logic [2:0]  matchEv;

  assign pinsRaw = {externalClearPin, externalCountPin,
                    captureInputD, captureInputC, captureInputB, captureInputA};

  // register index from the word address
  function automatic logic [7:0] regIndex(input logic [9:0] adr);
    regIndex = adr[9:2];
  endfunction : regIndex

  // read multiplexer; unmapped indices read as zero
  function automatic logic [7:0] readValue(
    input logic [7:0]                          idx,
    input capture_compare_timer16_pkg::state_t st
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      capture_compare_timer16_pkg::IDX_EVENT_FLAGS:  v = st.flags;
      capture_compare_timer16_pkg::IDX_CLEAR_TOGGLE: v = st.clearToggle;
      capture_compare_timer16_pkg::IDX_CONTROL:      v = st.control;
      capture_compare_timer16_pkg::IDX_EDGE_CONTROL: v = st.edgeCtl;
      capture_compare_timer16_pkg::IDX_SET_ENABLE:   v = st.setEnable;
      capture_compare_timer16_pkg::IDX_COUNT_LO:     v = st.count[7:0];  // live [RULE4]
      capture_compare_timer16_pkg::IDX_COUNT_HI:     v = st.count[15:8]; // live [RULE4]
      capture_compare_timer16_pkg::IDX_PORT:         v = st.port;
      default:                                       v = 8'h00;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (idx == 8'(capture_compare_timer16_pkg::IDX_CAPTURE_BASE + 2 * i)) begin
        v = st.capture[i][7:0];
      end
      if (idx == 8'(capture_compare_timer16_pkg::IDX_CAPTURE_BASE + 2 * i + 1)) begin
        v = st.capture[i][15:8];
      end
    end
    for (int j = 0; j < 3; j++) begin
      if (idx == 8'(capture_compare_timer16_pkg::IDX_COMPARE_BASE + 2 * j)) begin
        v = st.compare[j][7:0];
      end
      if (idx == 8'(capture_compare_timer16_pkg::IDX_COMPARE_BASE + 2 * j + 1)) begin
        v = st.compare[j][15:8];
      end
    end
    readValue = v;
  endfunction : readValue

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // three-stage pin synchronisers; a change counts once stages two and three agree
    s_next.syncA = pinsRaw;                              // [RULE21]
    s_next.syncB = s_reg.syncA;
    s_next.syncC = s_reg.syncB;
    stable = ~(s_reg.syncB ^ s_reg.syncC);
    rise = stable & s_reg.syncC & ~s_reg.level;          // [RULE21]
    fall = stable & ~s_reg.syncC & s_reg.level;          // [RULE21]
    s_next.level = (s_reg.level & ~stable) | (s_reg.syncC & stable);

    // bus: answer one cycle after the request, commit the write on the ack edge
    busReq = cyc_i & stb_i;
    index = regIndex(adr_i);
    wrByte = dat_i[7:0];
    wrCommit = busReq & s_reg.ack & we_i & sel_i[0];
    s_next.ack = busReq & ~s_reg.ack;
    s_next.readData = (busReq & ~s_reg.ack) ? {24'h000000, readValue(index, s_reg)} : 32'h0;

    ctrlWrite = wrCommit && index == capture_compare_timer16_pkg::IDX_CONTROL;
    flagWrite = wrCommit && index == capture_compare_timer16_pkg::IDX_EVENT_FLAGS;
    portWrite = wrCommit && index == capture_compare_timer16_pkg::IDX_PORT;

    // plain configuration registers
    if (wrCommit && index == capture_compare_timer16_pkg::IDX_EDGE_CONTROL) begin
      s_next.edgeCtl = wrByte;
    end
    if (wrCommit && index == capture_compare_timer16_pkg::IDX_SET_ENABLE) begin
      s_next.setEnable = wrByte;
    end
    if (wrCommit && index == capture_compare_timer16_pkg::IDX_CLEAR_TOGGLE) begin
      s_next.clearToggle = wrByte;
    end
    for (int j = 0; j < 3; j++) begin
      if (wrCommit && index == 8'(capture_compare_timer16_pkg::IDX_COMPARE_BASE + 2 * j)) begin
        s_next.compare[j][7:0] = wrByte;
      end
      if (wrCommit &&
          index == 8'(capture_compare_timer16_pkg::IDX_COMPARE_BASE + 2 * j + 1)) begin
        s_next.compare[j][15:8] = wrByte;
      end
    end

    // clock source and prescaler; a change of either clears the prescaler
    mode = s_reg.control[capture_compare_timer16_pkg::CTL_MODE_LSB +: 2];
    prescaleSel = s_reg.control[capture_compare_timer16_pkg::CTL_PRESCALE_LSB +: 2];
    cfgChange = ctrlWrite && (wrByte[3:0] != s_reg.control[3:0]);          // [RULE3]
    extClear = s_reg.control[capture_compare_timer16_pkg::CTL_EXT_CLEAR_EN]
               & rise[capture_compare_timer16_pkg::PIN_CLEAR];             // [RULE5]
    timerHold = lowPower | extClear;                                       // [RULE6]
    preClear = timerHold | cfgChange;                                      // [RULE3]

    divTick = (mode == capture_compare_timer16_pkg::MODE_SYSCLK) && s_reg.divider == DIV_LAST;
    case (mode)                                                            // [RULE2]
      capture_compare_timer16_pkg::MODE_SYSCLK:   tick = divTick;
      capture_compare_timer16_pkg::MODE_EXTERNAL: tick = rise[capture_compare_timer16_pkg::PIN_COUNT];
      default:                                    tick = 1'b0;  // halted; test code idles too
    endcase
    if (preClear || mode != capture_compare_timer16_pkg::MODE_SYSCLK || divTick) begin
      s_next.divider = 4'h0;
    end else begin
      s_next.divider = s_reg.divider + 4'h1;
    end
    if (preClear) begin
      s_next.prescale = 3'h0;                                              // [RULE3]
    end else if (tick) begin
      s_next.prescale = s_reg.prescale + 3'h1;                             // [RULE3]
    end

    // the counter steps when the low prescaler bits wrap for the chosen factor
    preMask = 3'((4'h1 << prescaleSel) - 4'h1);                            // [RULE1]
    cntStep = tick && !preClear && ((s_reg.prescale & preMask) == preMask); // [RULE1]
    byteOvf = cntStep && s_reg.count[7:0] == 8'hFF;                        // [RULE18]
    wordOvf = cntStep && s_reg.count == 16'hFFFF;                          // [RULE18]
    if (timerHold) begin
      s_next.count = 16'h0000;                                             // [RULE5] [RULE6]
    end else if (cntStep) begin
      s_next.count = s_reg.count + 16'h0001;
    end

    // captures copy the running count
    for (int i = 0; i < 4; i++) begin
      capEv[i] = (rise[i] & s_reg.edgeCtl[2 * i]) |                        // [RULE8]
                 (fall[i] & s_reg.edgeCtl[2 * i + 1]);                     // [RULE8]
      if (capEv[i]) begin
        s_next.capture[i] = s_reg.count;                                   // [RULE7]
      end
    end

    // compares act only on the first cycle of equality
    for (int j = 0; j < 3; j++) begin
      matchNow[j] = s_reg.count == s_reg.compare[j];                       // [RULE9]
    end
    matchEv = matchNow & ~s_reg.matchPrev;                                 // [RULE22]
    s_next.matchPrev = matchNow;

    // sticky flags: a hardware set wins over a software clear in the same cycle
    s_next.flags = (flagWrite ? wrByte : s_reg.flags) |                    // [RULE19]
                   {wordOvf, matchEv, capEv};                              // [RULE16] [RULE7]
    s_next.control = ctrlWrite ? wrByte : s_reg.control;
    if (byteOvf) begin
      s_next.control[capture_compare_timer16_pkg::CTL_BYTE_OVF_FLAG] = 1'b1; // [RULE18]
    end

    // output port: software write first, compare actions laid on top
    s_next.port = portWrite ? wrByte : s_reg.port;                         // [RULE17]
    if (matchEv[0]) begin
      s_next.port[5:0] = s_next.port[5:0] | s_reg.setEnable[5:0];          // [RULE10]
    end
    if (matchEv[1]) begin
      s_next.port[5:0] = s_next.port[5:0] & ~s_reg.clearToggle[5:0];       // [RULE11] [RULE14]
    end
    for (int b = 6; b < 8; b++) begin
      if (matchEv[2] && s_reg.clearToggle[b]) begin                        // [RULE12]
        s_next.port[b] = ~s_reg.setEnable[b];                              // [RULE13]
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // chip reset clears everything, the compare registers among them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg             <= '0;                                             // [RULE15]
      s_reg.control     <= capture_compare_timer16_pkg::RST_BYTE;
      s_reg.count       <= capture_compare_timer16_pkg::RST_WORD;          // [RULE5]
      s_reg.port        <= capture_compare_timer16_pkg::RST_PORT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dat_o   = s_reg.readData;
  assign ack_o   = s_reg.ack;
  assign portOut = s_reg.port;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_hold_clears: assert property ( // [RULE6]
    lowPower |=> s_reg.count == 16'h0000 && s_reg.prescale == 3'h0)
    else $error("counter or prescaler not cleared in low power");

  a_count_step: assert property ( // [RULE1]
    cntStep && !timerHold |=>
    s_reg.count == 16'($past(s_reg.count) + 16'h0001))
    else $error("counter did not advance on prescaler wrap");

  a_config_clear: assert property ( // [RULE3]
    cfgChange |=> s_reg.prescale == 3'h0 && s_reg.divider == 4'h0)
    else $error("prescaler kept value across a config change");

  a_halt_frozen: assert property ( // [RULE2]
    mode == capture_compare_timer16_pkg::MODE_HALTED
    && !timerHold |=> $stable(s_reg.count))
    else $error("halted counter moved");

  a_capture_load: assert property ( // [RULE7]
    capEv[0] |=>
    s_reg.capture[0] == $past(s_reg.count) && s_reg.flags[0])
    else $error("capture a missed count or flag");

  a_edge_disabled: assert property ( // [RULE8]
    s_reg.edgeCtl[1:0] == 2'h0 |=> $stable(s_reg.capture[0]))
    else $error("capture a loaded with both edges disabled");

  a_match_once: assert property ( // [RULE22]
    matchEv[0] |=> !matchEv[0] && s_reg.flags[4])
    else $error("set compare acted twice or left no flag");

  a_clear_priority: assert property ( // [RULE14]
    matchEv[0] && matchEv[1] |=>
    (s_reg.port[5:0] & $past(s_reg.clearToggle[5:0])) == 6'h00)
    else $error("set won over clear on a common match");

  a_toggle_dir: assert property ( // [RULE13]
    matchEv[2] && s_reg.clearToggle[7] |=>
    s_reg.port[7] == !$past(s_reg.setEnable[7]))
    else $error("toggle gave wrong level on port bit 7");

  a_flag_sticky: assert property ( // [RULE19]
    s_reg.flags[7] && !flagWrite |=> s_reg.flags[7])
    else $error("overflow flag dropped without software");

  a_word_ovf: assert property ( // [RULE18]
    wordOvf && !timerHold |=>
    s_reg.flags[7] && s_reg.count == 16'h0000 && s_reg.control[4])
    else $error("16-bit overflow did not set both flags");

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_ext_clear: assert property ( // [RULE5]
    extClear |=> s_reg.count == 16'h0000 && s_reg.prescale == 3'h0)
    else $error("external clear left counter or prescaler");

  a_pin_only: assert property ( // [RULE2]
    mode == capture_compare_timer16_pkg::MODE_EXTERNAL && !timerHold
    && !rise[capture_compare_timer16_pkg::PIN_COUNT] |=> $stable(s_reg.count))
    else $error("pin-clocked counter moved without a pin edge");

  a_set_bits: assert property ( // [RULE10]
    matchEv[0] && !matchEv[1] |=>
    (s_reg.port[5:0] & $past(s_reg.setEnable[5:0])) == $past(s_reg.setEnable[5:0]))
    else $error("set compare missed an enabled port bit");

  a_clear_bits: assert property ( // [RULE11]
    matchEv[1] |=> (s_reg.port[5:0] & $past(s_reg.clearToggle[5:0])) == 6'h00)
    else $error("clear compare left an enabled port bit high");

  a_toggle_off: assert property ( // [RULE12]
    matchEv[2] && !s_reg.clearToggle[6] && !portWrite |=> $stable(s_reg.port[6]))
    else $error("port bit 6 toggled while disabled");

  a_capture_d: assert property ( // [RULE7]
    capEv[3] |=> s_reg.capture[3] == $past(s_reg.count) && s_reg.flags[3])
    else $error("capture d missed count or flag");

  a_byte_ovf: assert property ( // [RULE18]
    byteOvf |=> s_reg.control[4])
    else $error("byte overflow flag not set");

  c_capture_both: cover property (capEv[0] && capEv[2]);
  c_set_clear:    cover property (matchEv[0] && matchEv[1]);
  c_toggle:       cover property (matchEv[2] && s_reg.clearToggle[6]);
  c_word_ovf:     cover property (wordOvf);

endmodule : capture_compare_timer16

/* bench/timer_pin_model.sv */
// pin-side partner: count, clear and capture inputs of the timer
// assumes clk is the timer clock; every pin moves just after a rising edge
`timescale 1ns/1ns

module timer_pin_model (
  input  wire logic       clk,
  output logic            countPin,
  output logic            clearPin,
  output logic      [3:0] capturePins
);
  // pins rest low until a task moves them
  initial begin
    countPin    = 1'b0;
    clearPin    = 1'b0;
    capturePins = 4'h0;
  end

  // each level lasts 12 clocks, so edges are never faster than clk/12
  task automatic count_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      countPin <= 1'b1;
      repeat (12) @(posedge clk);
      countPin <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask : count_pulses

  // one rising edge on the clear pin, then back low
  task automatic clear_pulse();
    @(posedge clk);
    clearPin <= 1'b1;
    repeat (12) @(posedge clk);
    clearPin <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : clear_pulse

  // move all capture pins together; the wait covers the synchroniser delay
  task automatic set_captures(input logic level);
    @(posedge clk);
    capturePins <= {4{level}};
    repeat (12) @(posedge clk);
  endtask : set_captures
endmodule : timer_pin_model

/* bench/test_capture_compare_timer16.sv */
// self-checking bench for the capture/compare timer over classic Wishbone
// assumes the pin model drives the timer pins; clk/12 shortened to clk/2
`timescale 1ns/1ns

module test_capture_compare_timer16;
  // ----------------------------------------------------------------
  // signals and register indices
  // ----------------------------------------------------------------
  localparam int         Div  = 2;
  localparam logic [7:0] FLG  = capture_compare_timer16_pkg::IDX_EVENT_FLAGS;
  localparam logic [7:0] CTL  = capture_compare_timer16_pkg::IDX_CONTROL;
  localparam logic [7:0] EDGE = capture_compare_timer16_pkg::IDX_EDGE_CONTROL;
  localparam logic [7:0] SETE = capture_compare_timer16_pkg::IDX_SET_ENABLE;
  localparam logic [7:0] CLRT = capture_compare_timer16_pkg::IDX_CLEAR_TOGGLE;
  localparam logic [7:0] CNT  = capture_compare_timer16_pkg::IDX_COUNT_LO;
  localparam logic [7:0] CAP  = capture_compare_timer16_pkg::IDX_CAPTURE_BASE;
  localparam logic [7:0] CMP  = capture_compare_timer16_pkg::IDX_COMPARE_BASE;
  localparam logic [7:0] PORT = capture_compare_timer16_pkg::IDX_PORT;
  localparam logic [7:0] ZERO_IDX [7] = '{CTL, EDGE, SETE, CLRT, CNT, PORT, 8'h00};
  localparam logic [7:0] CAP_EXP  [4] = '{8'h03, 8'h00, 8'h03, 8'h00};

  logic        clk, reset_n, cyc, stb, we, ack, countPin, clearPin, lowPower;
  logic [9:0]  adr;
  logic [3:0]  sel, capPins, selMask;
  logic [31:0] wdat, rdat;
  logic [7:0]  portOut;
  int          failures, cmp_count;

  capture_compare_timer16 #(.SysDivide(Div)) capture_compare_timer16_inst (
    .clk(clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .externalCountPin(countPin), .externalClearPin(clearPin),
    .captureInputA(capPins[0]), .captureInputB(capPins[1]),
    .captureInputC(capPins[2]), .captureInputD(capPins[3]),
    .lowPower(lowPower), .portOut(portOut));

  timer_pin_model timer_pin_model_inst (
    .clk(clk), .countPin(countPin), .clearPin(clearPin), .capturePins(capPins));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // one classic cycle; the request stands until ack is sampled high
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr;
    adr  <= {idx, 2'b00};
    sel  <= selMask;
    wdat <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) begin
      failures++;
      report_and_stop();
    end
  endtask : bus

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  // counts taken against a free-running prescaler land within a small window
  task automatic check_range(input string name, input logic [7:0] lo,
                             input logic [7:0] hi, input logic [7:0] got);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("unexpected %s expected %h..%h seen %h", name, lo, hi, got);
    end
  endtask : check_range

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus(1'b1, idx, d, unused);
  endtask : wr

  task automatic chk_reg(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    check8(name, exp, v);
  endtask : chk_reg

  // ----------------------------------------------------------------
  // clock and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    logic [7:0] v;
    {reset_n, cyc, stb, we, lowPower} = 5'h00;
    adr       = 10'h000;
    sel       = 4'h0;
    selMask   = 4'h1;
    wdat      = 32'h00000000;
    failures  = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_reg("flags at reset", FLG, 8'h70);
    foreach (ZERO_IDX[i]) chk_reg("reset value", ZERO_IDX[i], 8'h00);
    for (int i = 0; i < 6; i++) chk_reg("compare reset", CMP + 8'(i), 8'h00);
    wr(8'h00, 8'hA5);
    chk_reg("unmapped", 8'h00, 8'h00);
    selMask = 4'h0;
    wr(SETE, 8'hFF);
    selMask = 4'h1;
    chk_reg("masked write", SETE, 8'h00);
    $display("reset test done");
    // each prescale code runs 24 counts' worth of clocks after a low-power clear
    for (int p = 0; p < 4; p++) begin
      lowPower <= 1'b1;
      wr(CTL, 8'(p << 2) | 8'h01);
      chk_reg("count in low power", CNT, 8'h00);
      lowPower <= 1'b0;
      repeat (24 * (Div << p)) @(posedge clk);
      bus(1'b0, CNT, 8'h00, v);
      check_range("count per prescale", 8'd22, 8'd26, v);
    end
    lowPower <= 1'b1;
    wr(CTL, 8'h00);
    lowPower <= 1'b0;
    repeat (40) @(posedge clk);
    chk_reg("halted count", CNT, 8'h00);
    $display("prescaler test done");
    wr(CTL, 8'h23);
    timer_pin_model_inst.count_pulses(5);
    chk_reg("pin count", CNT, 8'h05);
    wr(CNT, 8'hAA);
    chk_reg("count after write", CNT, 8'h05);
    timer_pin_model_inst.clear_pulse();
    chk_reg("count after clear", CNT, 8'h00);
    wr(CTL, 8'h03);
    timer_pin_model_inst.count_pulses(3);
    timer_pin_model_inst.clear_pulse();
    chk_reg("clear disabled", CNT, 8'h03);
    $display("pin test done");
    wr(EDGE, 8'h39);
    wr(FLG, 8'h00);
    timer_pin_model_inst.set_captures(1'b1);
    chk_reg("flags after rise", FLG, 8'h05);
    for (int i = 0; i < 4; i++) chk_reg("capture", CAP + 8'(2 * i), CAP_EXP[i]);
    wr(FLG, 8'h00);
    timer_pin_model_inst.set_captures(1'b0);
    repeat (20) @(posedge clk);
    chk_reg("flags after fall", FLG, 8'h06);
    chk_reg("capture b", CAP + 8'h02, 8'h03);
    $display("capture test done");
    wr(SETE, 8'h0F);
    wr(FLG, 8'h00);
    wr(CMP, 8'h03);
    chk_reg("flags set match", FLG, 8'h10);
    check8("port after set", 8'h0F, portOut);
    wr(FLG, 8'h00);
    repeat (10) @(posedge clk);
    chk_reg("flags while equal", FLG, 8'h00);
    wr(PORT, 8'h33);
    chk_reg("port readback", PORT, 8'h33);
    wr(CLRT, 8'h03);
    wr(CMP + 8'h02, 8'h03);
    repeat (2) @(posedge clk);
    check8("port after clear", 8'h30, portOut);
    wr(PORT, 8'h55);
    wr(SETE, 8'h7F);
    wr(CLRT, 8'hBF);
    for (int i = 0; i < 6; i += 2) wr(CMP + 8'(i), 8'h04);
    wr(FLG, 8'h00);
    timer_pin_model_inst.count_pulses(1);
    check8("port double match", 8'hC0, portOut);
    chk_reg("flags all compares", FLG, 8'h70);
    wr(SETE, 8'h80);
    wr(CMP + 8'h04, 8'h05);
    timer_pin_model_inst.count_pulses(1);
    check8("port toggle low", 8'h40, portOut);
    $display("compare test done");
    wr(CTL, 8'h01);
    repeat (600) @(posedge clk);
    chk_reg("byte overflow flag", CTL, 8'h11);
    bus(1'b0, FLG, 8'h00, v);
    check8("word overflow flag", 8'h00, v & 8'h80);
    $display("overflow test done");
    report_and_stop();
  end
endmodule : test_capture_compare_timer16
